// File: dfc_regs.svh
// Register offsets, field positions, reset values and fixed-point constants of the filter chain
`ifndef DFC_REGS_SVH
`define DFC_REGS_SVH

// ==========================================================================
// Register byte offsets
`define DFC_OFF_CTRL      8'h00
`define DFC_OFF_RATE      8'h04
`define DFC_OFF_CUTOFF    8'h08
`define DFC_OFF_STATUS    8'h0c
`define DFC_OFF_COEF_ADDR 8'h10
`define DFC_OFF_COEF_DATA 8'h14
`define DFC_OFF_COUNT     8'h18

// ==========================================================================
// Field positions
`define DFC_CTRL_EN_BIT     0
`define DFC_CTRL_MODE_LSB   1
`define DFC_CTRL_MODE_MSB   3
`define DFC_STAT_BUSY_BIT   0
`define DFC_STAT_REFUSE_BIT 1
`define DFC_STAT_FULL_BIT   2
`define DFC_STAT_LEVEL_LSB  3

// ==========================================================================
// Reset values
`define DFC_CTRL_RST   4'h0
`define DFC_RATE_RST   16'h0001
`define DFC_CUTOFF_RST 16'h0000
`define DFC_COEF_UNITY 16'h4000
`define DFC_COEF_ZERO  16'h0000

// ==========================================================================
// Fixed-point format of the biquad coefficients (Q2.14)
`define DFC_COEF_FRAC  14
`define DFC_SECTIONS   4

`endif

// File: dfc_pkg.sv
// Types shared by the decimation filter chain
package dfc_pkg;

  typedef enum logic [2:0] {
    DFC_MODE_AAF = 3'h0,
    DFC_MODE_AVG = 3'h1,
    DFC_MODE_BES = 3'h2,
    DFC_MODE_BUT = 3'h3,
    DFC_MODE_BYP = 3'h4
  } dfc_mode_t;

  typedef enum logic [1:0] {
    DFC_ST_IDLE = 2'h0,
    DFC_ST_FILT = 2'h1,
    DFC_ST_DONE = 2'h3
  } dfc_state_t;

endpackage : dfc_pkg

// File: dfc_filter.sv
// Decimation filter chain: APB registers, biquad cascade, averager, result FIFO
// Function
// - Reduce primary-rate samples to selected output rate
// - Average mode emits mean of N samples
// - N equals primary rate over output rate
// - Anti-aliasing mode runs eighth-order elliptic cascade
// - Anti-aliasing cut-off set by bank 0 coefficients, not by output rate
// - Elliptic response: deep stop band, tiny ripple
// - Average response nulls at output rate
// - Bessel mode: constant delay, small overshoot
// - Butterworth mode: flat pass band
// - Bypass mode decimates without digital filtering
// - Bypass refused at primary rate on variants
// - Fixed-point filter is exact and repeatable
`timescale 1ns/1ps
`include "dfc_regs.svh"

// ==========================================================================
// Result FIFO
module dfc_fifo #(
  parameter int W = 24,
  parameter int D = 16
) (
  input  wire logic                   mclk,
  input  wire logic                   resetn,
  input  wire logic                   wr_valid,
  output logic                        wr_ready,
  input  wire logic [W-1:0]           wr_data,
  output logic                        rd_valid,
  input  wire logic                   rd_ready,
  output logic [W-1:0]                rd_data,
  output logic [$clog2(D):0]          level
);
  localparam int AW = $clog2(D);

  logic [W-1:0]  mem [0:D-1];
  logic [AW:0]   wr_ptr;
  logic [AW:0]   rd_ptr;
  logic          push;
  logic          pop;

  assign level    = wr_ptr - rd_ptr;
  assign wr_ready = (level != (AW+1)'(D));
  assign rd_valid = (level != '0);
  assign rd_data  = mem[rd_ptr[AW-1:0]];
  assign push     = wr_valid & wr_ready;
  assign pop      = rd_valid & rd_ready;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule : dfc_fifo

// ==========================================================================
// Top of the chain
module dfc_filter #(
  parameter int DW             = 24,
  parameter int FIFO_DEPTH     = 16,
  parameter bit BYPASS_AT_PRIM = 1'b0
) (
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  input  wire logic [7:0]            paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  in_valid,
  input  wire logic [DW-1:0]         in_data,
  output logic                       in_ready,
  output logic                       out_valid,
  output logic [DW-1:0]              out_data,
  input  wire logic                  out_ready,
  output dfc_pkg::dfc_mode_t         eff_mode
);
  import dfc_pkg::*;

  localparam int XW  = DW + 19;
  localparam int LW  = $clog2(FIFO_DEPTH) + 1;
  localparam int NC  = 128;

  // ========================================================================
  // Helpers
  function automatic logic signed [DW-1:0] sat(input logic signed [XW-1:0] v);
    logic signed [XW-1:0] hi;
    logic signed [XW-1:0] lo;
    hi = XW'({1'b0, {(DW-1){1'b1}}});
    lo = ~hi;
    if (v > hi) begin
      sat = hi[DW-1:0];
    end else if (v < lo) begin
      sat = lo[DW-1:0];
    end else begin
      sat = v[DW-1:0];
    end
  endfunction : sat

  function automatic logic is_off(input logic [7:0] a, input logic [7:0] off);
    is_off = (a == off);
  endfunction : is_off

  // ========================================================================
  // Registers and state
  logic                    enable;
  logic [2:0]              mode_sel;
  logic [15:0]             rate;
  logic [15:0]             cutoff;
  logic [6:0]              coef_addr;
  logic [31:0]             res_count;
  logic signed [15:0]      coef [0:NC-1];
  logic                    refused;
  logic                    flush;
  logic                    do_wr;
  logic                    cfg_wr;
  logic                    unmapped;
  logic [31:0]             rd_mux;
  dfc_mode_t               mode_now;
  logic [15:0]             n_eff;

  dfc_state_t              state;
  dfc_state_t              next_state;
  logic [1:0]              sec;
  logic signed [DW-1:0]    cur;
  logic signed [DW-1:0]    sx1 [0:3];
  logic signed [DW-1:0]    sx2 [0:3];
  logic signed [DW-1:0]    sy1 [0:3];
  logic signed [DW-1:0]    sy2 [0:3];
  logic [15:0]             dec_cnt;
  logic signed [DW+15:0]   avg_acc;
  logic signed [DW+16:0]   avg_sum;
  logic signed [DW+16:0]   avg_q;
  logic [1:0]              bank;
  logic signed [XW-1:0]    fsum;
  logic signed [DW-1:0]    ysec;
  logic                    take;
  logic                    last;
  logic                    is_filt;

  logic                    fifo_wr_valid;
  logic                    fifo_wr_ready;
  logic [DW-1:0]           fifo_wr_data;
  logic                    fifo_rd_valid;
  logic                    fifo_rd_ready;
  logic [DW-1:0]           fifo_rd_data;
  logic [LW-1:0]           fifo_level;

  // ========================================================================
  // Mode resolution
  always_comb begin
    n_eff    = (rate == 16'h0000) ? 16'h0001 : rate;
    mode_now = DFC_MODE_AAF;
    refused  = 1'b0;
    case (mode_sel)
      3'h1: mode_now = DFC_MODE_AVG;
      3'h2: mode_now = DFC_MODE_BES;
      3'h3: mode_now = DFC_MODE_BUT;
      3'h4: begin
        // Some channel variants cannot pass raw samples at the primary rate
        if (n_eff == 16'h0001 && !BYPASS_AT_PRIM) begin
          refused = 1'b1;
        end else begin
          mode_now = DFC_MODE_BYP;
        end
      end
      default: mode_now = DFC_MODE_AAF;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      eff_mode <= DFC_MODE_AAF;
    end else begin
      eff_mode <= mode_now;
    end
  end

  // ========================================================================
  // APB slave, one wait state
  assign do_wr    = psel & penable & pwrite & pready;
  assign cfg_wr   = do_wr & (is_off(paddr, `DFC_OFF_CTRL) | is_off(paddr, `DFC_OFF_RATE)
                             | is_off(paddr, `DFC_OFF_CUTOFF));
  assign unmapped = !(paddr inside {`DFC_OFF_CTRL, `DFC_OFF_RATE, `DFC_OFF_CUTOFF,
                                    `DFC_OFF_STATUS, `DFC_OFF_COEF_ADDR,
                                    `DFC_OFF_COEF_DATA, `DFC_OFF_COUNT});

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `DFC_OFF_CTRL:      rd_mux = 32'({mode_sel, enable});
      `DFC_OFF_RATE:      rd_mux = 32'(rate);
      `DFC_OFF_CUTOFF:    rd_mux = 32'(cutoff);
      `DFC_OFF_STATUS:    rd_mux = 32'({fifo_level, ~fifo_wr_ready, refused,
                                        (state != DFC_ST_IDLE)});
      `DFC_OFF_COEF_ADDR: rd_mux = 32'(coef_addr);
      `DFC_OFF_COEF_DATA: rd_mux = {16'h0000, coef[coef_addr]};
      `DFC_OFF_COUNT:     rd_mux = res_count;
      default:            rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & unmapped;
      if (psel & penable & ~pready & ~pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      enable    <= 1'b0;
      mode_sel  <= 3'h0;
      rate      <= `DFC_RATE_RST;
      cutoff    <= `DFC_CUTOFF_RST;
      coef_addr <= 7'h00;
      flush     <= 1'b0;
    end else begin
      flush <= cfg_wr;
      if (do_wr) begin
        case (paddr)
          `DFC_OFF_CTRL: begin
            enable   <= pwdata[`DFC_CTRL_EN_BIT];
            mode_sel <= pwdata[`DFC_CTRL_MODE_MSB:`DFC_CTRL_MODE_LSB];
          end
          `DFC_OFF_RATE:      rate      <= pwdata[15:0];
          `DFC_OFF_CUTOFF:    cutoff    <= pwdata[15:0];
          `DFC_OFF_COEF_ADDR: coef_addr <= pwdata[6:0];
          `DFC_OFF_COEF_DATA: coef_addr <= coef_addr + 7'h01;
          default:            coef_addr <= coef_addr;
        endcase
      end
    end
  end

  // Coefficients reset to a unity pass so an unloaded bank is harmless
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NC; i++) begin
        coef[i] <= ((i % 8) == 0) ? `DFC_COEF_UNITY : `DFC_COEF_ZERO;
      end
    end else if (do_wr && is_off(paddr, `DFC_OFF_COEF_DATA)) begin
      coef[coef_addr] <= pwdata[15:0];
    end
  end

  // ========================================================================
  // Biquad section, shared across the four sections of the cascade
  always_comb begin
    case (eff_mode)
      DFC_MODE_BES: bank = 2'h1;
      DFC_MODE_BUT: bank = 2'h2;
      default:      bank = 2'h0;
    endcase
  end

  // Integer arithmetic only, so equal settings give bit-identical results
  always_comb begin
    fsum = coef[{bank, sec, 3'h0}] * cur
         + coef[{bank, sec, 3'h1}] * sx1[sec]
         + coef[{bank, sec, 3'h2}] * sx2[sec]
         - coef[{bank, sec, 3'h3}] * sy1[sec]
         - coef[{bank, sec, 3'h4}] * sy2[sec];
    ysec = sat(fsum >>> `DFC_COEF_FRAC);
  end

  // ========================================================================
  // Sequencer
  assign is_filt  = (eff_mode == DFC_MODE_AAF) || (eff_mode == DFC_MODE_BES)
                  || (eff_mode == DFC_MODE_BUT);
  assign take     = (state == DFC_ST_IDLE) & in_valid & in_ready;
  assign last     = (dec_cnt == n_eff - 16'h0001);
  assign avg_sum  = (DW+17)'(avg_acc) + (DW+17)'(cur);
  assign avg_q    = avg_sum / $signed({1'b0, n_eff});

  assign fifo_wr_valid = (state == DFC_ST_DONE) & last & ~flush;
  assign fifo_wr_data  = (eff_mode == DFC_MODE_AVG) ? sat(XW'(avg_q)) : cur;

  always_comb begin
    next_state = state;
    case (state)
      DFC_ST_IDLE: begin
        if (take) begin
          next_state = is_filt ? DFC_ST_FILT : DFC_ST_DONE;
        end
      end
      DFC_ST_FILT: begin
        if (sec == 2'h3) begin
          next_state = DFC_ST_DONE;
        end
      end
      DFC_ST_DONE: begin
        if (!last || fifo_wr_ready) begin
          next_state = DFC_ST_IDLE;
        end
      end
      default: next_state = DFC_ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state    <= DFC_ST_IDLE;
      in_ready <= 1'b0;
    end else begin
      state    <= flush ? DFC_ST_IDLE : next_state;
      // The source waits while the cascade runs or the FIFO is full
      in_ready <= enable & ~cfg_wr & ~flush & (next_state == DFC_ST_IDLE);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sec     <= 2'h0;
      cur     <= '0;
      dec_cnt <= 16'h0000;
      avg_acc <= '0;
      for (int s = 0; s < `DFC_SECTIONS; s++) begin
        sx1[s] <= '0;
        sx2[s] <= '0;
        sy1[s] <= '0;
        sy2[s] <= '0;
      end
    end else if (flush) begin
      sec     <= 2'h0;
      dec_cnt <= 16'h0000;
      avg_acc <= '0;
      for (int s = 0; s < `DFC_SECTIONS; s++) begin
        sx1[s] <= '0;
        sx2[s] <= '0;
        sy1[s] <= '0;
        sy2[s] <= '0;
      end
    end else begin
      case (state)
        DFC_ST_IDLE: begin
          if (take) begin
            cur <= in_data;
            sec <= 2'h0;
          end
        end
        DFC_ST_FILT: begin
          sx1[sec] <= cur;
          sx2[sec] <= sx1[sec];
          sy1[sec] <= ysec;
          sy2[sec] <= sy1[sec];
          cur      <= ysec;
          sec      <= sec + 2'h1;
        end
        DFC_ST_DONE: begin
          if (!last) begin
            dec_cnt <= dec_cnt + 16'h0001;
            if (eff_mode == DFC_MODE_AVG) begin
              avg_acc <= avg_sum[DW+15:0];
            end
          end else if (fifo_wr_ready) begin
            dec_cnt <= 16'h0000;
            avg_acc <= '0;
          end
        end
        default: sec <= 2'h0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      res_count <= 32'h0000_0000;
    end else if (fifo_wr_valid & fifo_wr_ready) begin
      res_count <= res_count + 32'h0000_0001;
    end
  end

  // ========================================================================
  // Result FIFO and output stage
  dfc_fifo #(
    .W (DW),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .mclk     (mclk),
    .resetn   (resetn),
    .wr_valid (fifo_wr_valid),
    .wr_ready (fifo_wr_ready),
    .wr_data  (fifo_wr_data),
    .rd_valid (fifo_rd_valid),
    .rd_ready (fifo_rd_ready),
    .rd_data  (fifo_rd_data),
    .level    (fifo_level)
  );

  assign fifo_rd_ready = out_ready;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      out_valid <= fifo_rd_valid & out_ready;
      if (fifo_rd_valid & out_ready) begin
        out_data <= fifo_rd_data;
      end
    end
  end
endmodule : dfc_filter

// File: dfc_filter_sva.sv
// Port checker for the decimation filter chain, bound into its top module
`timescale 1ns/1ps
`include "dfc_regs.svh"
// ==========================================================================
// Checker
module dfc_filter_sva
  import dfc_pkg::*;
#(
  parameter int DW = 24
) (
  input wire logic               mclk,
  input wire logic               resetn,
  input wire logic [7:0]         paddr,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               in_valid,
  input wire logic [DW-1:0]      in_data,
  input wire logic               in_ready,
  input wire logic               out_valid,
  input wire logic [DW-1:0]      out_data,
  input wire logic               out_ready,
  input wire dfc_pkg::dfc_mode_t eff_mode
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic cfg_wr;
  // Any committed write to CTRL, RATE or CUTOFF flushes the chain
  assign cfg_wr = psel && penable && pready && pwrite && (paddr == `DFC_OFF_CTRL ||
                  paddr == `DFC_OFF_RATE || paddr == `DFC_OFF_CUTOFF);
  a_pready_single:
    assert property (pready |=> !pready) else $error("pready longer than one cycle");
  a_pready_answer:
    assert property (psel && penable && !pready |=> pready) else $error("no answer after access");
  a_pready_cause:
    assert property ($rose(pready) |-> $past(psel && penable)) else $error("pready without access");
  a_err_read_zero:
    assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
      else $error("bad error response");
  a_take_drops_ready:
    assert property (in_valid && in_ready |=> !in_ready) else $error("in_ready held after take");
  a_flush_blocks_input:
    assert property (cfg_wr |=> !in_ready) else $error("input accepted during flush");
  a_out_pulse_cause:
    assert property (out_valid |-> $past(out_ready)) else $error("result without consumer ready");
  a_mode_in_range:
    assert property (eff_mode inside {DFC_MODE_AAF, DFC_MODE_AVG, DFC_MODE_BES, DFC_MODE_BUT,
                     DFC_MODE_BYP}) else $error("illegal effective mode");
  c_cfg_write:   cover property (cfg_wr);
  c_err_read:    cover property (pslverr && !pwrite);
  c_result:      cover property (out_valid ##1 out_valid);
endmodule : dfc_filter_sva

bind dfc_filter dfc_filter_sva #(.DW(DW)) u_dfc_filter_sva (
  .mclk(mclk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready), .out_valid(out_valid),
  .out_data(out_data), .out_ready(out_ready), .eff_mode(eff_mode));

// File: dfc_src.sv
// Front-end sampler model: delivers a ramp of primary-rate samples
`timescale 1ns/1ps
// ==========================================================================
// Sampler
module dfc_src #(
  parameter int DW = 24
) (
  input  wire logic          mclk,
  input  wire logic          resetn,
  input  wire logic          go,
  input  wire logic [DW-1:0] first,
  input  wire logic [7:0]    cnt,
  input  wire logic [3:0]    gap,
  input  wire logic          in_ready,
  output logic               in_valid,
  output logic [DW-1:0]      in_data,
  output logic               busy
);
  logic [7:0]    left;
  logic [3:0]    wt;
  logic [DW-1:0] nxt;
  assign busy = (left != 8'h00) || in_valid;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      in_valid <= 1'b0;
      in_data  <= '0;
      left     <= 8'h00;
      wt       <= 4'h0;
      nxt      <= '0;
    end else if (go) begin
      left <= cnt;
      nxt  <= first;
      wt   <= 4'h0;
    end else if (in_valid && in_ready) begin
      in_valid <= 1'b0;
      // Released data is inverted so a stale sample is never re-read as valid
      in_data  <= ~in_data;
      nxt      <= nxt + 1'b1;
      left     <= left - 8'h01;
      wt       <= gap;
    end else if (wt != 4'h0) begin
      wt <= wt - 4'h1;
    end else if (!in_valid && left != 8'h00) begin
      in_valid <= 1'b1;
      in_data  <= nxt;
    end
  end
endmodule : dfc_src

// File: test_dfc_filter.sv
// Self-checking testbench of the decimation filter chain
`timescale 1ns/1ps
`include "dfc_regs.svh"
// ==========================================================================
// Bench
module test_dfc_filter;
  import dfc_pkg::*;
  logic        mclk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, in_valid, in_ready, out_valid, out_ready = 1'b1;
  logic        go = 1'b0, busy;
  logic [23:0] in_data, out_data, first = 24'h0;
  logic [7:0]  cnt = 8'h00;
  logic [3:0]  gap = 4'h0;
  dfc_mode_t   eff_mode;
  logic [31:0] outq[$];
  logic [31:0] r;
  logic        e;
  int          n_fail = 0, comparisons = 0;

  dfc_filter u_dfc_filter (.mclk(mclk), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
    .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready), .eff_mode(eff_mode));
  dfc_src u_dfc_src (.mclk(mclk), .resetn(resetn), .go(go), .first(first), .cnt(cnt),
    .gap(gap), .in_ready(in_ready), .in_valid(in_valid), .in_data(in_data), .busy(busy));

  always #5 mclk = ~mclk;
  always @(posedge mclk) if (out_valid === 1'b1) outq.push_back(32'(signed'(out_data)));

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Holds the whole request until pready is seen high at an edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic mode(input dfc_mode_t m);
    apb(`DFC_OFF_CTRL, 1'b1, {28'h0, m, 1'b1});
    repeat (3) @(posedge mclk);
  endtask : mode
  task automatic send(input logic [23:0] f, input logic [7:0] c, input logic [3:0] g);
    @(posedge mclk);
    go    <= 1'b1;
    first <= f;
    cnt   <= c;
    gap   <= g;
    @(posedge mclk);
    go <= 1'b0;
    @(posedge mclk);
    while (busy) @(posedge mclk);
  endtask : send
  task automatic waitout(input int n);
    while (outq.size() < n) @(posedge mclk);
  endtask : waitout

  task automatic t_regs();
    apb(`DFC_OFF_CTRL, 1'b0, 32'h0);
    chk(r, 32'h0);
    apb(`DFC_OFF_RATE, 1'b0, 32'h0);
    chk(r, 32'h1);
    apb(`DFC_OFF_COUNT, 1'b0, 32'h0);
    chk(r, 32'h0);
    apb(8'h1c, 1'b0, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    apb(`DFC_OFF_CUTOFF, 1'b1, 32'h0123);
    apb(`DFC_OFF_CUTOFF, 1'b0, 32'h0);
    chk(r, 32'h0123);
  endtask : t_regs
  // Unity coefficients make every biquad mode an exact pass-through
  task automatic t_filters();
    dfc_mode_t ms[3] = '{DFC_MODE_AAF, DFC_MODE_BES, DFC_MODE_BUT};
    foreach (ms[i]) begin
      // Host keeps the Bessel output rate near five times its cut-off
      if (ms[i] == DFC_MODE_BES) apb(`DFC_OFF_CUTOFF, 1'b1, 32'h0005);
      mode(ms[i]);
      chk({29'h0, eff_mode}, {29'h0, ms[i]});
      send(24'd100, 8'd2, 4'h0);
      waitout(2);
      chk(outq.pop_front(), 32'd100);
      chk(outq.pop_front(), 32'd101);
    end
  endtask : t_filters
  task automatic t_avg();
    apb(`DFC_OFF_RATE, 1'b1, 32'h4);
    mode(DFC_MODE_AVG);
    send(24'd10, 8'd4, 4'h0);
    send(-24'sd5, 8'd4, 4'h3);
    send(24'd50, 8'd2, 4'h0);
    apb(`DFC_OFF_RATE, 1'b1, 32'h4);
    send(24'd20, 8'd4, 4'h0);
    waitout(3);
    chk(outq.pop_front(), 32'd11);
    chk(outq.pop_front(), -32'sd3);
    chk(outq.pop_front(), 32'd21);
  endtask : t_avg
  task automatic t_bypass();
    mode(DFC_MODE_BYP);
    chk({29'h0, eff_mode}, {29'h0, DFC_MODE_BYP});
    send(24'd1, 8'd4, 4'h0);
    waitout(1);
    chk(outq.pop_front(), 32'd4);
    apb(`DFC_OFF_RATE, 1'b1, 32'h1);
    repeat (3) @(posedge mclk);
    chk({29'h0, eff_mode}, {29'h0, DFC_MODE_AAF});
    apb(`DFC_OFF_STATUS, 1'b0, 32'h0);
    chk(r & 32'h2, 32'h2);
  endtask : t_bypass
  task automatic t_fifo();
    out_ready <= 1'b0;
    mode(DFC_MODE_AAF);
    // The seventeenth result finds the FIFO full and holds the input off
    send(24'd200, 8'd17, 4'h0);
    repeat (8) @(posedge mclk);
    apb(`DFC_OFF_STATUS, 1'b0, 32'h0);
    chk(r & 32'hfc, 32'h84);
    chk({31'h0, in_ready}, 32'h0);
    out_ready <= 1'b1;
    waitout(17);
    for (int i = 0; i < 17; i++) chk(outq.pop_front(), 32'd200 + 32'(i));
    apb(`DFC_OFF_COUNT, 1'b0, 32'h0);
    chk(r, 32'd29);
  endtask : t_fifo
  // A b1 tap of one in the first elliptic section gives y = x + x[n-1]
  task automatic t_coef();
    apb(`DFC_OFF_COEF_ADDR, 1'b1, 32'h01);
    apb(`DFC_OFF_COEF_DATA, 1'b1, 32'h4000);
    apb(`DFC_OFF_COEF_ADDR, 1'b0, 32'h0);
    chk(r, 32'h02);
    apb(`DFC_OFF_COEF_ADDR, 1'b1, 32'h01);
    apb(`DFC_OFF_COEF_DATA, 1'b0, 32'h0);
    chk(r, 32'h4000);
    mode(DFC_MODE_AAF);
    send(24'd10, 8'd2, 4'h0);
    waitout(2);
    chk(outq.pop_front(), 32'd10);
    chk(outq.pop_front(), 32'd21);
    apb(`DFC_OFF_COEF_DATA, 1'b1, 32'h0);
  endtask : t_coef
  task automatic t_reset();
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    apb(`DFC_OFF_RATE, 1'b0, 32'h0);
    chk(r, 32'h1);
    chk({31'h0, in_ready}, 32'h0);
    chk({29'h0, eff_mode}, {29'h0, DFC_MODE_AAF});
    apb(`DFC_OFF_COUNT, 1'b0, 32'h0);
    chk(r, 32'h0);
  endtask : t_reset

  initial begin
    #200us;
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end
  initial begin
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_filters();
    t_coef();
    t_avg();
    t_bypass();
    t_fifo();
    t_reset();
    conclude();
  end
endmodule : test_dfc_filter
